/* rop_power_seq.sv */
// clock-only low-power sequencer with the domain register file
`include "rop_consts.svh"
module rop_power_seq #(
  parameter int TICKS_PER_SEC = `ROP_TICKS_PER_SEC,
  parameter int SYS_RST_CYC   = `ROP_SYS_RST_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_rtc_clk,
  input  wire logic                  i_wake,
  input  wire logic                  i_core_above_thr,
  input  wire logic [15:0]           i_io_addr,
  input  wire logic                  i_io_wr,
  input  wire logic                  i_io_rd,
  input  wire rop_pkg::rop_word_type i_io_wdata,
  output rop_pkg::rop_word_type      o_io_rdata,
  output logic                       o_io_rd_valid,
  output logic                       o_wr_pending,
  output logic                       o_core_reg_en,
  output logic                       o_core_power_good,
  output logic                       o_rtc_isolate,
  output logic                       o_sys_reset_n
);
  import rop_pkg::*;

  localparam int PW = $clog2(TICKS_PER_SEC);

  function automatic rop_idx_type ofs_idx(input logic [15:0] addr);
    logic [15:0] ofs;
    ofs = addr - `ROP_REG_BASE;
    return {ofs[6:2], ofs[0]};
  endfunction

  // holes alias in the folded index, so they must miss here
  function automatic logic addr_mapped(input logic [15:0] addr);
    logic hit;
    if (addr == `ROP_OFS_INT_EN) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_UPDATE) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MS_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MS_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SEC_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SEC_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MIN_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MIN_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_HOUR_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_HOUR_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_DAY_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_DAY_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MON_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_MON_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_YEAR_CNT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_YEAR_ALM) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_INT_FLAGS) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_LOST_PWR) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_PER_SEL) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_DRIFT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_OSC_CTRL) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_PWR_MGMT) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SCR1) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SCR2) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SCR3) begin
      hit = 1'b1;
    end else if (addr == `ROP_OFS_SCR4) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // returns {carry, next value} of a two-digit bcd count
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim);
    logic [8:0] r;
    if (v >= lim) begin
      r = {1'b1, 8'h00};
    end else if (v[3:0] >= 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  localparam rop_idx_type UPD_IDX  = ofs_idx(`ROP_OFS_UPDATE);
  localparam rop_idx_type SEC_IDX  = ofs_idx(`ROP_OFS_SEC_CNT);
  localparam rop_idx_type MIN_IDX  = ofs_idx(`ROP_OFS_MIN_CNT);
  localparam rop_idx_type HOUR_IDX = ofs_idx(`ROP_OFS_HOUR_CNT);
  localparam rop_idx_type LOST_IDX = ofs_idx(`ROP_OFS_LOST_PWR);
  localparam rop_idx_type OSC_IDX  = ofs_idx(`ROP_OFS_OSC_CTRL);
  localparam rop_idx_type PMGT_IDX = ofs_idx(`ROP_OFS_PWR_MGMT);
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICKS_PER_SEC - 1);
  localparam logic [15:0]   RST_LAST   = 16'(SYS_RST_CYC - 1);

  // sparse map folded into 64 words; unmapped slots are never written
  rop_word_type      regs_r [0:63];
  rop_pwr_state_type state_r;
  rop_pwr_state_type state_nxt;
  logic [15:0]       rst_cnt_r;
  logic [PW-1:0]     presc_r;
  logic              rtc_d_r;

  logic [2:0]  sync_out;
  wire         rtc_s = sync_out[0];
  wire         wake_s = sync_out[1];
  wire         thr_s = sync_out[2];

  rop_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_core_above_thr, i_wake, i_rtc_clk}),
    .o_sync   (sync_out)
  );

  // domain clock rising edge, seen on the fast clock
  wire rtc_edge = rtc_s & ~rtc_d_r;
  wire osc_on   = ~regs_r[OSC_IDX][`ROP_OSC_OFF_BIT];
  wire tick     = rtc_edge & osc_on;

  wire         cpu_ok    = (state_r == PS_ON);
  wire         addr_hit  = addr_mapped(i_io_addr);
  rop_idx_type addr_idx;
  assign addr_idx = ofs_idx(i_io_addr);

  wire wr_take = i_io_wr & cpu_ok & addr_hit & osc_on;
  // cpu access only out of isolation
  wire rd_take = i_io_rd & cpu_ok & addr_hit;

  logic         cm_valid;
  rop_idx_type  cm_idx;
  rop_word_type cm_data;

  rop_wr_stage u_wr (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_load   (wr_take),
    .i_idx    (addr_idx),
    .i_data   (i_io_wdata),
    .i_tick   (tick),
    .o_busy   (o_wr_pending),
    .o_commit (cm_valid),
    .o_idx    (cm_idx),
    .o_data   (cm_data)
  );

  wire pd_any = regs_r[PMGT_IDX][`ROP_PMGT_REG_PD_BIT] |
                regs_r[PMGT_IDX][`ROP_PMGT_BANDGAP_POWERDOWN_BIT_BIT];

  // raw domain edge: a stopped oscillator must not block wake-up
  // wake only counts on a domain edge
  wire wake_go = (state_r == PS_OFF) & rtc_edge & wake_s;

  wire       sec_step = tick & (presc_r == PRESC_LAST);
  wire [8:0] sec_inc  = bcd_inc(regs_r[SEC_IDX][7:0], `ROP_SEC_MAX);
  wire [8:0] min_inc  = bcd_inc(regs_r[MIN_IDX][7:0], `ROP_SEC_MAX);
  wire [8:0] hour_inc = bcd_inc(regs_r[HOUR_IDX][7:0], `ROP_HOUR_MAX);
  wire       min_step  = sec_step & sec_inc[8];
  wire       hour_step = min_step & min_inc[8];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PS_ON: begin
        if (pd_any) begin
          state_nxt = PS_OFF;
        end else if (!thr_s) begin
          state_nxt = PS_RAMP;
        end
      end
      PS_OFF: begin
        if (wake_go) begin
          state_nxt = PS_RAMP;
        end
      end
      PS_RAMP: begin
        if (thr_s) begin
          state_nxt = PS_RESET;
        end
      end
      PS_RESET: begin
        if (!thr_s) begin
          state_nxt = PS_RAMP;
        end else if (rst_cnt_r == RST_LAST) begin
          state_nxt = PS_ON;
        end
      end
      default: state_nxt = PS_RAMP;
    endcase
  end

  wire pg_nxt = (state_nxt == PS_RESET) | (state_nxt == PS_ON);

  // only the domain power-on reset clears these
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r           <= PS_RAMP;
      rst_cnt_r         <= 16'h0000;
      rtc_d_r           <= 1'b0;
      o_core_reg_en     <= 1'b1;
      o_core_power_good <= 1'b0;
      o_rtc_isolate     <= 1'b1;
      o_sys_reset_n     <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      rst_cnt_r         <= (state_r == PS_RESET) ? rst_cnt_r + 16'h0001 : 16'h0000;
      rtc_d_r           <= rtc_s;
      o_core_reg_en     <= (state_nxt != PS_OFF);
      o_core_power_good <= pg_nxt;
      o_rtc_isolate     <= ~pg_nxt;
      o_sys_reset_n     <= (state_nxt == PS_ON);
    end
  end

  // every read strobe is answered, even refused ones, so the cpu never stalls
  // register answers; refused reads return zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_io_rdata    <= `ROP_REG_RESET;
      o_io_rd_valid <= 1'b0;
    end else begin
      o_io_rdata    <= rd_take ? regs_r[addr_idx] : `ROP_REG_RESET;
      o_io_rd_valid <= i_io_rd;
    end
  end

  // seconds prescaler on the domain clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_r <= '0;
    end else if (tick) begin
      presc_r <= (presc_r == PRESC_LAST) ? '0 : presc_r + PW'(1);
    end
  end

  // later assignments take priority: commit over count, wake over commit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < 64; k++) begin
        regs_r[k] <= `ROP_REG_RESET;
      end
      regs_r[LOST_IDX] <= `ROP_LOST_PWR_RESET;
    end else begin
      if (sec_step) begin
        regs_r[SEC_IDX][7:0] <= sec_inc[7:0];
      end
      if (min_step) begin
        regs_r[MIN_IDX][7:0] <= min_inc[7:0];
      end
      if (hour_step) begin
        regs_r[HOUR_IDX][7:0] <= hour_inc[7:0];
      end
      if (cm_valid) begin
        regs_r[cm_idx] <= cm_data;
      end
      if (wake_go) begin
        regs_r[PMGT_IDX][`ROP_PMGT_REG_PD_BIT] <= 1'b0;
        regs_r[PMGT_IDX][`ROP_PMGT_BANDGAP_POWERDOWN_BIT_BIT]  <= 1'b0;
      end
      // cleared while power-good is low so a stale update is never replayed
      // update control lost without core power
      if (!o_core_power_good) begin
        regs_r[UPD_IDX] <= `ROP_REG_RESET;
      end
    end
  end
endmodule

/* rop_consts.svh */
// constants for the clock-only power sequencer
`ifndef ROP_CONSTS_SVH
`define ROP_CONSTS_SVH

`define ROP_OFS_INT_EN     16'h1900
`define ROP_OFS_UPDATE     16'h1901
`define ROP_OFS_MS_CNT     16'h1904
`define ROP_OFS_MS_ALM     16'h1905
`define ROP_OFS_SEC_CNT    16'h1908
`define ROP_OFS_SEC_ALM    16'h1909
`define ROP_OFS_MIN_CNT    16'h190c
`define ROP_OFS_MIN_ALM    16'h190d
`define ROP_OFS_HOUR_CNT   16'h1910
`define ROP_OFS_HOUR_ALM   16'h1911
`define ROP_OFS_DAY_CNT    16'h1914
`define ROP_OFS_DAY_ALM    16'h1915
`define ROP_OFS_MON_CNT    16'h1918
`define ROP_OFS_MON_ALM    16'h1919
`define ROP_OFS_YEAR_CNT   16'h191c
`define ROP_OFS_YEAR_ALM   16'h191d
`define ROP_OFS_INT_FLAGS  16'h1920
`define ROP_OFS_LOST_PWR   16'h1921
`define ROP_OFS_PER_SEL    16'h1924
`define ROP_OFS_DRIFT      16'h1928
`define ROP_OFS_OSC_CTRL   16'h192c
`define ROP_OFS_PWR_MGMT   16'h1930
`define ROP_OFS_SCR1       16'h1960
`define ROP_OFS_SCR2       16'h1961
`define ROP_OFS_SCR3       16'h1964
`define ROP_OFS_SCR4       16'h1965
`define ROP_REG_BASE       16'h1900

`define ROP_PMGT_REG_PD_BIT 1
`define ROP_PMGT_BANDGAP_POWERDOWN_BIT_BIT  2
`define ROP_OSC_OFF_BIT     0

`define ROP_REG_RESET      16'h0000
`define ROP_LOST_PWR_RESET 16'h0001

`define ROP_CLK_MHZ        10
`define ROP_DOMAIN_PER_NS  30500
`define ROP_MIN_CPU_RATIO  3
`define ROP_WR_SYNC_TICKS  2
`define ROP_TICKS_PER_SEC  32768
`define ROP_SYS_RST_NS     1000
`define ROP_SYS_RST_CYC    ((`ROP_SYS_RST_NS * `ROP_CLK_MHZ + 999) / 1000)
`define ROP_SEC_MAX        8'h59
`define ROP_HOUR_MAX       8'h23

`endif

/* rop_pkg.sv */
// types shared by the power sequencer files
package rop_pkg;
  typedef logic [15:0] rop_word_type;
  typedef logic [5:0]  rop_idx_type;
  typedef enum logic [1:0] {
    PS_ON,
    PS_OFF,
    PS_RAMP,
    PS_RESET
  } rop_pwr_state_type;
endpackage

/* rop_sync.sv */
// two-flop synchroniser for pin-level inputs
module rop_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  import rop_pkg::*;

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

/* rop_wr_stage.sv */
// holds one cpu write until two domain clock edges have passed
`include "rop_consts.svh"
module rop_wr_stage (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_load,
  input  wire rop_pkg::rop_idx_type  i_idx,
  input  wire rop_pkg::rop_word_type i_data,
  input  wire logic                  i_tick,
  output logic                       o_busy,
  output logic                       o_commit,
  output rop_pkg::rop_idx_type       o_idx,
  output rop_pkg::rop_word_type      o_data
);
  import rop_pkg::*;

  localparam logic [1:0] LAST_TICK = 2'(`ROP_WR_SYNC_TICKS - 1);

  logic [1:0] tick_cnt_r;
  wire        done = o_busy & i_tick & (tick_cnt_r == LAST_TICK);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy     <= 1'b0;
      o_commit   <= 1'b0;
      o_idx      <= '0;
      o_data     <= '0;
      tick_cnt_r <= 2'h0;
    end else begin
      o_commit <= done;
      if (i_load && !o_busy) begin
        o_busy     <= 1'b1;
        o_idx      <= i_idx;
        o_data     <= i_data;
        tick_cnt_r <= 2'h0;
      end else if (done) begin
        o_busy <= 1'b0;
      end else if (o_busy && i_tick) begin
        tick_cnt_r <= tick_cnt_r + 2'h1;
      end
    end
  end
endmodule

/* rop_power_seq_properties.sv */
// port-level assertions for the clock-only power sequencer
module rop_power_seq_chk #(
  parameter int TICKS_PER_SEC = 32768,
  parameter int SYS_RST_CYC   = 10
) (
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  input wire logic                  i_rtc_clk,
  input wire logic                  i_wake,
  input wire logic                  i_core_above_thr,
  input wire logic                  i_io_wr,
  input wire logic                  i_io_rd,
  input wire rop_pkg::rop_word_type o_io_rdata,
  input wire logic                  o_io_rd_valid,
  input wire logic                  o_wr_pending,
  input wire logic                  o_core_reg_en,
  input wire logic                  o_core_power_good,
  input wire logic                  o_rtc_isolate,
  input wire logic                  o_sys_reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import rop_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [1:0] rtc_r;
  logic [2:0] tick_r;
  logic [3:0] wake_age_r;
  // raw edge seen earlier than the design's synced tick, so count is never short
  wire        tick_w = rtc_r == 2'b01;
  wire        take_w = i_io_wr && !o_wr_pending;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rtc_r <= 2'b00;
      tick_r <= 3'h0;
      wake_age_r <= 4'hf;
    end else begin
      rtc_r <= {rtc_r[0], i_rtc_clk};
      if (take_w) tick_r <= {2'b00, tick_w};
      else if (tick_w && tick_r != 3'h7) tick_r <= tick_r + 3'h1;
      if (i_wake) wake_age_r <= 4'h0;
      else if (wake_age_r != 4'hf) wake_age_r <= wake_age_r + 4'h1;
    end
  end
  sequence s_hold;
    !o_sys_reset_n [*8];
  endsequence
  sequence s_free;
    ##[1:40] o_sys_reset_n;
  endsequence
  pg_iso_a: assert property (o_rtc_isolate == !o_core_power_good)
    else $error("isolation not inverse of power-good");
  thr_low_a: assert property (!i_core_above_thr [*5] |-> !o_core_power_good)
    else $error("power-good high below threshold");
  off_pg_a: assert property (!o_core_reg_en |-> !o_core_power_good && !o_sys_reset_n)
    else $error("power-good with regulator off");
  pg_rise_a: assert property ($rose(o_core_power_good) |-> $past(i_core_above_thr, 2))
    else $error("power-good rose without threshold");
  rst_seq_a: assert property ($rose(o_core_power_good) |-> s_hold ##0 s_free)
    else $error("system reset release out of window");
  rd_valid_a: assert property (i_io_rd |=> o_io_rd_valid)
    else $error("read not answered");
  rd_zero_a: assert property (!o_io_rd_valid |-> o_io_rdata == '0)
    else $error("read data not idle");
  wr_min_a: assert property ($fell(o_wr_pending) |-> tick_r >= 3'h2)
    else $error("write landed before two domain ticks");
  wr_max_a: assert property ($rose(o_wr_pending) |-> ##[1:60] !o_wr_pending)
    else $error("write never landed");
  wake_a: assert property ($rose(o_core_reg_en) |-> wake_age_r < 4'h8)
    else $error("regulator on without wake");
endmodule
bind rop_power_seq rop_power_seq_chk #(.TICKS_PER_SEC(TICKS_PER_SEC), .SYS_RST_CYC(SYS_RST_CYC))
  i_rop_power_seq_chk (.i_clk, .i_arst_n, .i_rtc_clk, .i_wake, .i_core_above_thr, .i_io_wr,
  .i_io_rd, .o_io_rdata, .o_io_rd_valid, .o_wr_pending, .o_core_reg_en, .o_core_power_good,
  .o_rtc_isolate, .o_sys_reset_n);

/* rop_far_side.sv */
// far-side model: crystal clock, wake source and regulator ramp
module rop_far_side #(
  parameter int RTC_HALF_NS = 1000,
  parameter int RAMP_CYC    = 30
) (
  input  wire logic i_clk,
  input  wire logic i_reg_en,
  output logic      o_rtc_clk,
  output logic      o_wake,
  output logic      o_above_thr
);
  timeunit 1ns;
  timeprecision 1ns;
  int ramp_r;
  initial begin
    o_rtc_clk = 1'b0;
    o_wake = 1'b0;
    o_above_thr = 1'b0;
    ramp_r = 0;
  end
  // crystal runs free, also while the core is off
  always #(RTC_HALF_NS) o_rtc_clk = ~o_rtc_clk;
  always @(posedge i_clk) begin
    if (!i_reg_en) begin
      ramp_r <= 0;
      o_above_thr <= 1'b0;
    end else if (ramp_r < RAMP_CYC) begin
      ramp_r <= ramp_r + 1;
    end else begin
      o_above_thr <= 1'b1;
    end
  end
  // wake held high for whole cycles
  task automatic wake(input int cyc);
    @(posedge i_clk);
    o_wake <= 1'b1;
    repeat (cyc) @(posedge i_clk);
    o_wake <= 1'b0;
  endtask
  // short pulse kept well clear of a crystal edge
  task automatic glitch();
    @(posedge o_rtc_clk);
    repeat (5) @(posedge i_clk);
    o_wake <= 1'b1;
    @(posedge i_clk);
    o_wake <= 1'b0;
  endtask
endmodule

/* rop_power_seq_tb.sv */
// self-checking bench for the power sequencer
`include "rop_consts.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end
module rop_power_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rop_pkg::*;
  logic         i_clk;
  logic         i_arst_n;
  logic         rtc_clk, wake, thr, rd, wr;
  logic [15:0]  addr;
  rop_word_type wdata, rdata;
  logic         rd_valid, pend, reg_en, pg, iso, sys_n;
  int           err_count, checked;
  logic [15:0]  ra [6] = '{`ROP_OFS_SCR1, `ROP_OFS_SCR2, `ROP_OFS_SCR3, `ROP_OFS_SCR4,
                         `ROP_OFS_LOST_PWR, 16'h1902};
  rop_word_type rv [6] = '{`ROP_REG_RESET, `ROP_REG_RESET, `ROP_REG_RESET, `ROP_REG_RESET,
                         `ROP_LOST_PWR_RESET, 16'h0000};
  rop_word_type pdv [2] = '{16'h0001 << `ROP_PMGT_REG_PD_BIT, 16'h0001 << `ROP_PMGT_BANDGAP_POWERDOWN_BIT_BIT};
  rop_power_seq #(.TICKS_PER_SEC(4), .SYS_RST_CYC(10)) i_rop_power_seq (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rtc_clk(rtc_clk), .i_wake(wake),
    .i_core_above_thr(thr), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rd_valid(rd_valid),
    .o_wr_pending(pend), .o_core_reg_en(reg_en), .o_core_power_good(pg),
    .o_rtc_isolate(iso), .o_sys_reset_n(sys_n));
  rop_far_side i_rop_far_side (.i_clk(i_clk), .i_reg_en(reg_en), .o_rtc_clk(rtc_clk),
    .o_wake(wake), .o_above_thr(thr));
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  task automatic summarize();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_lv(ref logic s, input logic v, input int n);
    int k = 0;
    while (s !== v && k < n) begin
      @(posedge i_clk);
      k++;
    end
    #1;
    checked++;
    if (s !== v) begin
      err_count++;
      $display("ERROR wait exp %h got %h", v, s);
      summarize();
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input rop_word_type exp);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rdata", exp, rdata)
  endtask
  task automatic wr_do(input logic [15:0] a, input rop_word_type v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    #1;
  endtask
  initial begin
    err_count = 0;
    checked = 0;
    i_arst_n = 1'b0;
    addr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    repeat (12) @(posedge i_clk);
    `CHK("reset outs", 4'b1010, {reg_en, pg, iso, sys_n})
    i_arst_n <= 1'b1;
    wait_lv(sys_n, 1'b1, 300);
    `CHK("iso", 1'b0, iso)
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    wr_do(`ROP_OFS_SCR1, 16'ha5a5);
    `CHK("pend", 1'b1, pend)
    rd_chk(`ROP_OFS_SCR1, 16'h0000);
    wr_do(`ROP_OFS_SCR2, 16'h5a5a);
    wait_lv(pend, 1'b0, 80);
    rd_chk(`ROP_OFS_SCR1, 16'ha5a5);
    rd_chk(`ROP_OFS_SCR2, 16'h0000);
    // seconds at the wrap value, so one minute carry is due well before the last read
    wr_do(`ROP_OFS_SEC_CNT, 16'h0059);
    wait_lv(pend, 1'b0, 80);
    wr_do(`ROP_OFS_UPDATE, 16'h0003);
    wait_lv(pend, 1'b0, 80);
    rd_chk(`ROP_OFS_UPDATE, 16'h0003);
    foreach (pdv[b]) begin
      wr_do(`ROP_OFS_PWR_MGMT, pdv[b]);
      wait_lv(reg_en, 1'b0, 80);
      `CHK("off", 3'b010, {pg, iso, sys_n})
      rd_chk(`ROP_OFS_SCR1, 16'h0000);
      i_rop_far_side.glitch();
      repeat (60) @(posedge i_clk);
      `CHK("glitch", 1'b0, reg_en)
      i_rop_far_side.wake(25);
      wait_lv(sys_n, 1'b1, 300);
      rd_chk(`ROP_OFS_SCR1, 16'ha5a5);
      rd_chk(`ROP_OFS_PWR_MGMT, 16'h0000);
    end
    rd_chk(`ROP_OFS_MIN_CNT, 16'h0001);
    rd_chk(`ROP_OFS_UPDATE, 16'h0000);
    // oscillator stopped last: it cannot be restarted by a write
    wr_do(`ROP_OFS_OSC_CTRL, 16'h0001 << `ROP_OSC_OFF_BIT);
    wait_lv(pend, 1'b0, 80);
    wr_do(`ROP_OFS_SCR3, 16'h1234);
    `CHK("osc off pend", 1'b0, pend)
    repeat (60) @(posedge i_clk);
    rd_chk(`ROP_OFS_SCR3, 16'h0000);
    summarize();
  end
endmodule
